// file: common/tvtc_consts.vh
`ifndef TVTC_CONSTS_VH
`define TVTC_CONSTS_VH

// System clock rate in MHz
`define TVTC_CLK_MHZ        25
// Measuring cycle timing in microseconds
`define TVTC_PROC_US        1280
`define TVTC_CYC256_US      6400
`define TVTC_CYC64_US       2560
// Quiet time the master keeps after a reset
`define TVTC_RST_WAIT_US    50
// Derived cycle counts
`define TVTC_PROC_CLKS      (`TVTC_PROC_US * `TVTC_CLK_MHZ)
`define TVTC_CYC256_CLKS    (`TVTC_CYC256_US * `TVTC_CLK_MHZ)
`define TVTC_CYC64_CLKS     (`TVTC_CYC64_US * `TVTC_CLK_MHZ)

// Bus addressing
`define TVTC_ADDR_HI        5'h18
`define TVTC_GCALL_ADDR     8'h00
`define TVTC_GCALL_RST      8'h06

// Instruction byte codes
`define TVTC_INS_TCD0       8'h29
`define TVTC_INS_TCD1       8'h2a
`define TVTC_INS_TCD2       8'h2b
`define TVTC_INS_PORT       8'h2c
`define TVTC_INS_FREQ_B     7

// Field positions, first control byte
`define TVTC_T0_MINV0_B     6
`define TVTC_T0_HOLD_LSB    4
`define TVTC_T0_CUR_LSB     2
`define TVTC_T0_WIN_LSB     0
// Field positions, second control byte
`define TVTC_T1_MINV1_B     7
`define TVTC_T1_CORR_LSB    5
`define TVTC_T1_GAIN_LSB    3
`define TVTC_T1_SENS_LSB    0
// Field positions, third control byte
`define TVTC_T2_POL_B       3
`define TVTC_T2_MSEL_B      2
`define TVTC_T2_DOWN_B      1
`define TVTC_T2_UP_B        0

// Reset values
`define TVTC_RST_FREQ       15'h7fff
`define TVTC_RST_CTRL       8'h00
`define TVTC_RST_PORT       8'hf0

// Deviation limits in 50 kHz steps
`define TVTC_WIN1_LIM       16'h0001
`define TVTC_WIN2_LIM       16'h0003
`define TVTC_HOLD1_LIM      16'h0007
`define TVTC_HOLD2_LIM      16'h000f

`endif

// file: hw/tvtc_mwin.v
`timescale 1ns/1ps
`default_nettype none
// Measuring cycle timer: processing phase first, then counting phase
module tvtc_mwin #(
  parameter integer PROC_CLKS   = 32000,   // Processing phase length
  parameter integer CYC256_CLKS = 160000,  // Cycle with divide-by-256
  parameter integer CYC64_CLKS  = 64000    // Cycle with divide-by-64
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire sel_i,       // Short cycle select
  output reg  mw_n_o,      // High while results are processed
  output reg  done_o       // Pulse at end of counting phase
);
  reg  [17:0] cnt_q;       // Position within the cycle
  wire [17:0] last_w;      // Last count of the cycle

  // Cycle length follows the window select
  assign last_w = sel_i ? CYC64_CLKS[17:0] - 18'h1 : CYC256_CLKS[17:0] - 18'h1;

  // Free running cycle counter with phase decode
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 18'h0;
      mw_n_o <= 1'b1;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (cnt_q >= last_w) begin
        cnt_q  <= 18'h0;
        mw_n_o <= 1'b1;    // Processing starts
        done_o <= 1'b1;    // Count is complete
      end else begin
        cnt_q <= cnt_q + 18'h1;
        if (cnt_q == PROC_CLKS[17:0] - 18'h1) begin
          mw_n_o <= 1'b0;  // Counting starts
        end
      end
    end
  end
endmodule // tvtc_mwin
`default_nettype wire

// file: hw/tvtc_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "tvtc_consts.vh"

// Notes on behaviour
// - Lock flag and tuning stop inside window
// - AFC stays on within hold range
// - Two-bit field selects AFC transconductance
// - Polarity bit sets AFC correction direction
// - Reset clears min-voltage and direction bits
// - Window select matches prescaler cycle timing
// - In-band field scales charge per band
// - Same scaling on gain, except lowest
// - Low port bits drive band outputs
// - Zero on high bits pulls port low
// - Read stops on missing master acknowledge
// - Lock-gained flag low on lock rise
// - Lock-lost flag low on lock fall
// - Overflow bit shows oscillator above target
// - Reset-occurred flag low after any reset
// - Window status high during processing time
// - Port rise flags clear after read
// - Port fall flags clear after read
// - Level bits report four port inputs
// - General call resets on 06h only
// - Bit seven loads fifteen-bit frequency word
// - Acknowledge valid address unless powered down
// - Both force bits suspend tuning, AFC on
module tvtc_ctrl #(
  parameter integer PROC_CLKS   = `TVTC_PROC_CLKS,
  parameter integer CYC256_CLKS = `TVTC_CYC256_CLKS,
  parameter integer CYC64_CLKS  = `TVTC_CYC64_CLKS
) (
  input  wire       CLK_SYS_I,
  input  wire       SYS_RST_I,
  input  wire       SCL_I,
  input  wire       SDA_I,
  output wire       SDA_O,
  output wire       SDA_OE_O,
  input  wire       PWR_DOWN_I,
  input  wire [1:0] MODULE_ADDR_I,
  input  wire       PRESCALED_OSC_I,
  input  wire [1:0] VTUN_BAND_I,
  input  wire [3:0] OC_PORT_I,
  output wire [3:0] OC_PORT_O,
  output wire [3:0] OC_PORT_OE_O,
  output wire [3:0] BAND_OUT_O,
  output wire       LOCK_FLAG_O,
  output wire       AFC_ACTIVE_O,
  output wire       MEASURE_WINDOW_N_O,
  output wire       TUNE_UP_O,
  output wire       TUNE_DOWN_O,
  output wire [1:0] TUNING_CURRENT_SEL_O,
  output wire [2:0] SENSITIVITY_SEL_O,
  output wire [1:0] MIN_TUNE_VOLTAGE_SEL_O,
  output wire [1:0] AFC_GAIN_SEL_O,
  output wire       AFC_POLARITY_O,
  output reg  [3:0] CHARGE_FACTOR_O,
  output reg  [3:0] AFC_GM_FACTOR_O
);
  // Bus slave states
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_RX   = 3'd1;
  localparam [2:0] ST_ACK  = 3'd2;
  localparam [2:0] ST_TX   = 3'd3;
  localparam [2:0] ST_MACK = 3'd4;

  // Input synchronisers, two stages
  reg  [11:0] sa_q;        // First stage
  reg  [11:0] sb_q;        // Second stage
  reg  [4:0]  sc_q;        // Delayed copy for edge detect
  wire        scl_w   = sb_q[0];
  wire        sda_w   = sb_q[1];
  wire        pd_w    = sb_q[2];
  wire [1:0]  ma_w    = sb_q[4:3];
  wire        osc_w   = sb_q[5];
  wire [1:0]  band_w  = sb_q[7:6];
  wire [3:0]  lvl_w   = sb_q[11:8];

  always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      // Idle levels: bus lines and pulled-up ports high, so no false edge
      sa_q <= 12'hf03;
      sb_q <= 12'hf03;
      sc_q <= 5'h1b;
    end else begin
      sa_q <= {OC_PORT_I, VTUN_BAND_I, PRESCALED_OSC_I, MODULE_ADDR_I,
               PWR_DOWN_I, SDA_I, SCL_I};
      sb_q <= sa_q;
      sc_q <= {lvl_w[3:2], osc_w, sda_w, scl_w};
    end
  end

  // Edge events on synchronised lines
  wire scl_rise = scl_w & ~sc_q[0];
  wire scl_fall = ~scl_w & sc_q[0];
  wire start_w  = scl_w & sc_q[0] & ~sda_w & sc_q[1];
  wire stop_w   = scl_w & sc_q[0] & sda_w & ~sc_q[1];
  wire osc_rise = osc_w & ~sc_q[2];
  wire p2_rise  = lvl_w[2] & ~sc_q[3];
  wire p2_fall  = ~lvl_w[2] & sc_q[3];
  wire p3_rise  = lvl_w[3] & ~sc_q[4];
  wire p3_fall  = ~lvl_w[3] & sc_q[4];

  // Programmable registers
  reg  [14:0] freq_q;      // Target frequency word
  reg  [7:0]  tcd0_q;      // Window, hold range, current, min voltage
  reg  [7:0]  tcd1_q;      // Correction, gain, sensitivity
  reg  [3:0]  tcd2_q;      // Polarity, window select, force bits
  reg  [7:0]  port_output_data_q;
  reg         gc_rst_q;    // Programmed reset pulse
  wire        rst_all = SYS_RST_I | pd_w | gc_rst_q;

  // Field views
  wire [1:0] tuning_window_sel     = tcd0_q[`TVTC_T0_WIN_LSB +: 2];
  wire [1:0] afc_hold_range_sel    = tcd0_q[`TVTC_T0_HOLD_LSB +: 2];
  wire [1:0] inband_correction_sel = tcd1_q[`TVTC_T1_CORR_LSB +: 2];
  wire [1:0] afc_gain_sel          = tcd1_q[`TVTC_T1_GAIN_LSB +: 2];
  wire       measure_window_sel    = tcd2_q[`TVTC_T2_MSEL_B];
  wire       force_up              = tcd2_q[`TVTC_T2_UP_B];
  wire       force_down            = tcd2_q[`TVTC_T2_DOWN_B];
  wire       force_both            = force_up & force_down;

  // Static control outputs
  assign TUNING_CURRENT_SEL_O   = tcd0_q[`TVTC_T0_CUR_LSB +: 2];
  assign SENSITIVITY_SEL_O      = tcd1_q[`TVTC_T1_SENS_LSB +: 3];
  assign MIN_TUNE_VOLTAGE_SEL_O = {tcd1_q[`TVTC_T1_MINV1_B],
                                   tcd0_q[`TVTC_T0_MINV0_B]};
  assign AFC_GAIN_SEL_O         = afc_gain_sel;
  assign AFC_POLARITY_O         = tcd2_q[`TVTC_T2_POL_B];
  assign BAND_OUT_O             = port_output_data_q[3:0];
  assign OC_PORT_O              = 4'h0;
  assign OC_PORT_OE_O           = ~port_output_data_q[7:4];

  // Bus slave state
  reg  [2:0] st_q;         // Slave state
  reg  [3:0] bit_q;        // Bits in current byte
  reg  [7:0] sh_q;         // Receive shifter
  reg  [7:0] tx_q;         // Transmit shifter
  reg  [1:0] idx_q;        // Received byte index
  reg  [1:0] rdi_q;        // Transmitted byte index
  reg        ack_q;        // Acknowledge to drive
  reg        rd_q;         // Read transfer
  reg        gc_q;         // General call transfer
  reg  [7:0] ins_q;        // Held instruction byte
  reg        clr0_q;       // Tuning byte was sent
  reg        clr1_q;       // Port byte was sent
  reg        wr_q;         // Data byte ready to apply

  // Status flags, active low ones idle high
  reg        lock_flag_q;
  reg        afc_active_q;
  reg        freq_over_q;
  reg        lock_gained_n_q;
  reg        lock_lost_n_q;
  reg        reset_occurred_n_q;
  reg        port3_rise_n_q;
  reg        port2_rise_n_q;
  reg        port3_fall_n_q;
  reg        port2_fall_n_q;
  wire       mw_n;         // Measuring window status
  wire       meas_done;    // Count complete

  assign SDA_O              = 1'b0;
  assign SDA_OE_O           = (st_q == ST_ACK & ack_q) | (st_q == ST_TX & ~tx_q[7]);
  assign LOCK_FLAG_O        = lock_flag_q;
  assign AFC_ACTIVE_O       = afc_active_q;
  assign MEASURE_WINDOW_N_O = mw_n;

  // Read-back bytes
  function [7:0] rd_byte;
    input [1:0] i;
    begin
      case (i)
        2'd0:    rd_byte = {lock_flag_q, lock_gained_n_q, lock_lost_n_q,
                            freq_over_q, reset_occurred_n_q, mw_n, 2'b00};
        2'd1:    rd_byte = {port3_rise_n_q, port2_rise_n_q, port3_fall_n_q,
                            port2_fall_n_q, lvl_w};
        default: rd_byte = 8'hff;
      endcase
    end
  endfunction

  // Serial bus slave sequencing
  always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I | pd_w) begin
      st_q     <= ST_IDLE;
      bit_q    <= 4'h0;
      sh_q     <= 8'h0;
      tx_q     <= 8'hff;
      idx_q    <= 2'd0;
      rdi_q    <= 2'd0;
      ack_q    <= 1'b0;
      rd_q     <= 1'b0;
      gc_q     <= 1'b0;
      ins_q    <= 8'h0;
      clr0_q   <= 1'b0;
      clr1_q   <= 1'b0;
      wr_q     <= 1'b0;
      gc_rst_q <= 1'b0;
    end else begin
      clr0_q   <= 1'b0;
      clr1_q   <= 1'b0;
      wr_q     <= 1'b0;
      gc_rst_q <= 1'b0;
      if (start_w) begin
        // Start or repeated start
        st_q  <= ST_RX;
        bit_q <= 4'h0;
        idx_q <= 2'd0;
      end else if (stop_w) begin
        st_q <= ST_IDLE;
      end else begin
        case (st_q)
          ST_RX: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_w};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall & bit_q == 4'h8) begin
              // Byte complete, decide acknowledge
              bit_q <= 4'h0;
              st_q  <= ST_ACK;
              ack_q <= 1'b1;
              if (idx_q != 2'd3) begin
                idx_q <= idx_q + 2'd1;
              end
              if (idx_q == 2'd0) begin
                rd_q  <= sh_q[0];
                gc_q  <= (sh_q == `TVTC_GCALL_ADDR);
                rdi_q <= 2'd0;
                ack_q <= (sh_q == `TVTC_GCALL_ADDR) |
                         (sh_q[7:1] == {`TVTC_ADDR_HI, ma_w}) |
                         (sh_q[7:1] == {`TVTC_ADDR_HI, 2'b00});
              end else if (gc_q) begin
                gc_rst_q <= (idx_q == 2'd1) & (sh_q == `TVTC_GCALL_RST);
              end else if (idx_q == 2'd1) begin
                ins_q <= sh_q;
              end else if (idx_q == 2'd2) begin
                wr_q <= 1'b1;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (~ack_q) begin
                st_q <= ST_IDLE;
              end else if (rd_q) begin
                st_q  <= ST_TX;
                tx_q  <= rd_byte(rdi_q);
              end else begin
                st_q <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              tx_q  <= {tx_q[6:0], 1'b1};
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h7) begin
                // Byte sent, flags may now clear
                bit_q  <= 4'h0;
                st_q   <= ST_MACK;
                clr0_q <= (rdi_q == 2'd0);
                clr1_q <= (rdi_q == 2'd1);
                if (rdi_q != 2'd2) begin
                  rdi_q <= rdi_q + 2'd1;
                end
              end
            end
          end
          ST_MACK: begin
            if (scl_rise & sda_w) begin
              st_q <= ST_IDLE;
            end else if (scl_fall) begin
              st_q <= ST_TX;
              tx_q <= rd_byte(rdi_q);
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Register writes from instruction and data bytes
  always @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      freq_q             <= `TVTC_RST_FREQ;
      tcd0_q             <= `TVTC_RST_CTRL;
      tcd1_q             <= `TVTC_RST_CTRL;
      tcd2_q             <= 4'h0;
      port_output_data_q <= `TVTC_RST_PORT;
    end else if (wr_q) begin
      if (ins_q[`TVTC_INS_FREQ_B]) begin
        freq_q <= {ins_q[6:0], sh_q};
      end else begin
        case (ins_q)
          `TVTC_INS_TCD0: tcd0_q <= sh_q;
          `TVTC_INS_TCD1: tcd1_q <= sh_q;
          `TVTC_INS_TCD2: tcd2_q <= sh_q[3:0];
          `TVTC_INS_PORT: port_output_data_q <= sh_q;
          default:        tcd2_q <= tcd2_q;
        endcase
      end
    end
  end

  // Measuring cycle timer
  tvtc_mwin #(
    .PROC_CLKS   (PROC_CLKS),
    .CYC256_CLKS (CYC256_CLKS),
    .CYC64_CLKS  (CYC64_CLKS)
  ) u_mwin (
    .clk_i  (CLK_SYS_I),
    .rst_i  (rst_all),
    .sel_i  (measure_window_sel),
    .mw_n_o (mw_n),
    .done_o (meas_done)
  );

  // Frequency count during the counting phase
  reg  [15:0] fcnt_q;
  always @(posedge CLK_SYS_I) begin
    if (rst_all | meas_done) begin
      fcnt_q <= 16'h0;
    end else if (osc_rise & ~mw_n & fcnt_q != 16'hffff) begin
      fcnt_q <= fcnt_q + 16'h1;
    end
  end

  // Deviation in 50 kHz steps, count minus target
  wire [16:0] dev_w   = {1'b0, fcnt_q} - {2'b00, freq_q};
  wire [16:0] ndev_w  = 17'h0 - dev_w;
  wire [15:0] adev_w  = dev_w[16] ? ndev_w[15:0] : dev_w[15:0];
  reg  [15:0] win_lim;
  reg  [15:0] hold_lim;

  // Window and hold-range limits
  always @* begin
    case (tuning_window_sel)
      2'b01:   win_lim = `TVTC_WIN1_LIM;
      2'b10:   win_lim = `TVTC_WIN2_LIM;
      default: win_lim = 16'h0;
    endcase
    case (afc_hold_range_sel)
      2'b01:   hold_lim = `TVTC_HOLD1_LIM;
      2'b10:   hold_lim = `TVTC_HOLD2_LIM;
      default: hold_lim = 16'h0;
    endcase
  end

  wire in_lock  = adev_w < win_lim;
  wire afc_next = force_both |
                  (afc_active_q & adev_w < hold_lim) |
                  in_lock;
  reg  tune_up_q;
  reg  tune_down_q;
  assign TUNE_UP_O   = tune_up_q;
  assign TUNE_DOWN_O = tune_down_q;

  // Loop decision once per measuring cycle
  always @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      lock_flag_q  <= 1'b0;
      afc_active_q <= 1'b0;
      freq_over_q  <= 1'b0;
      tune_up_q    <= 1'b0;
      tune_down_q  <= 1'b0;
    end else if (meas_done) begin
      lock_flag_q  <= in_lock;
      afc_active_q <= afc_next;
      freq_over_q  <= ~dev_w[16] & (dev_w != 17'h0);
      if (force_both | afc_next) begin
        tune_up_q   <= 1'b0;
        tune_down_q <= 1'b0;
      end else begin
        tune_up_q   <= force_up | (~force_down & dev_w[16]);
        tune_down_q <= force_down | (~force_up & ~dev_w[16]);
      end
    end
  end

  wire lock_rise = meas_done & in_lock & ~lock_flag_q;
  wire lock_fall = meas_done & ~in_lock & lock_flag_q;

  // Clear-on-read flags; a new event beats the clear
  always @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      reset_occurred_n_q <= 1'b0;
      lock_gained_n_q    <= 1'b1;
      lock_lost_n_q      <= 1'b1;
      port3_rise_n_q     <= 1'b1;
      port2_rise_n_q     <= 1'b1;
      port3_fall_n_q     <= 1'b1;
      port2_fall_n_q     <= 1'b1;
    end else begin
      reset_occurred_n_q <= reset_occurred_n_q | clr0_q;
      lock_gained_n_q    <= ~lock_rise & (lock_gained_n_q | clr0_q);
      lock_lost_n_q      <= ~lock_fall & (lock_lost_n_q | clr0_q);
      port3_rise_n_q     <= ~p3_rise & (port3_rise_n_q | clr1_q);
      port2_rise_n_q     <= ~p2_rise & (port2_rise_n_q | clr1_q);
      port3_fall_n_q     <= ~p3_fall & (port3_fall_n_q | clr1_q);
      port2_fall_n_q     <= ~p2_fall & (port2_fall_n_q | clr1_q);
    end
  end

  // Charge and transconductance factors by tuning-voltage band
  always @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      CHARGE_FACTOR_O <= 4'h1;
      AFC_GM_FACTOR_O <= 4'h1;
    end else begin
      case ({inband_correction_sel, band_w})
        4'b0111: CHARGE_FACTOR_O <= 4'h2;
        4'b1010: CHARGE_FACTOR_O <= 4'h2;
        4'b1011: CHARGE_FACTOR_O <= 4'h4;
        4'b1101: CHARGE_FACTOR_O <= 4'h2;
        4'b1110: CHARGE_FACTOR_O <= 4'h4;
        4'b1111: CHARGE_FACTOR_O <= 4'h8;
        default: CHARGE_FACTOR_O <= 4'h1;
      endcase
      // Lowest gain setting stays unscaled
      if (afc_gain_sel == 2'b00) begin
        AFC_GM_FACTOR_O <= 4'h1;
      end else begin
        case ({inband_correction_sel, band_w})
          4'b0111: AFC_GM_FACTOR_O <= 4'h2;
          4'b1010: AFC_GM_FACTOR_O <= 4'h2;
          4'b1011: AFC_GM_FACTOR_O <= 4'h4;
          4'b1101: AFC_GM_FACTOR_O <= 4'h2;
          4'b1110: AFC_GM_FACTOR_O <= 4'h4;
          4'b1111: AFC_GM_FACTOR_O <= 4'h8;
          default: AFC_GM_FACTOR_O <= 4'h1;
        endcase
      end
    end
  end
endmodule // tvtc_ctrl
`default_nettype wire

// file: sim/tvtc_master.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master model; clock idles high, data only ever pulled low
module tvtc_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_dn_o
);
  // Idle bus
  initial begin
    scl_o = 1'b1;
    sda_dn_o = 1'b0;
  end
  // Quarter of a bus bit
  task automatic q;
    repeat (2) @(posedge clk_i);
  endtask
  // One bit out, one bit seen at clock high
  task automatic bt(input logic b, output logic r);
    sda_dn_o <= !b;
    q();
    scl_o <= 1'b1;
    q();
    r = sda_i;
    q();
    scl_o <= 1'b0;
    q();
  endtask
  // Start condition
  task automatic st;
    sda_dn_o <= 1'b1;
    q();
    scl_o <= 1'b0;
    q();
  endtask
  // Stop condition, bus left released
  task automatic sp;
    sda_dn_o <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    sda_dn_o <= 1'b0;
    q();
  endtask
  // Byte out, then ninth bit l; low l acknowledges a read byte
  task automatic xb(input logic [7:0] d, input logic l, output logic [7:0] r,
                    output logic s);
    for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
    bt(l, s);
  endtask
endmodule // tvtc_master
`default_nettype wire

// file: sim/tvtc_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port relations of the tuning controller
module tvtc_chk #(
  parameter integer PROC_CLKS = 32000
) (
  input wire logic       CLK_SYS_I,
  input wire logic       SYS_RST_I,
  input wire logic       PWR_DOWN_I,
  input wire logic       SDA_O,
  input wire logic       SDA_OE_O,
  input wire logic [3:0] OC_PORT_O,
  input wire logic [3:0] OC_PORT_OE_O,
  input wire logic [3:0] BAND_OUT_O,
  input wire logic       LOCK_FLAG_O,
  input wire logic       AFC_ACTIVE_O,
  input wire logic       MEASURE_WINDOW_N_O,
  input wire logic       TUNE_UP_O,
  input wire logic       TUNE_DOWN_O,
  input wire logic [1:0] MIN_TUNE_VOLTAGE_SEL_O,
  input wire logic [1:0] AFC_GAIN_SEL_O,
  input wire logic       AFC_POLARITY_O,
  input wire logic [3:0] CHARGE_FACTOR_O,
  input wire logic [3:0] AFC_GM_FACTOR_O
);
  logic [31:0] hi_q;   // Length of the present high phase
  logic        seen_q; // High phase began without reset or bus traffic
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  // Measure the processing phase; skip phases a reset may have stretched
  always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I || !MEASURE_WINDOW_N_O) begin
      hi_q <= 32'h0;
    end else begin
      hi_q <= hi_q + 32'h1;
    end
    if (SYS_RST_I || PWR_DOWN_I || SDA_OE_O) begin
      seen_q <= 1'b0;
    end else if ($rose(MEASURE_WINDOW_N_O)) begin
      seen_q <= 1'b1;
    end
  end
  chk_reset_ports: assert property (disable iff (1'b0)
    SYS_RST_I |=> BAND_OUT_O == 4'h0 && OC_PORT_OE_O == 4'h0 && !SDA_OE_O)
    else $error("ports not cleared by reset");
  chk_reset_fields: assert property (disable iff (1'b0)
    SYS_RST_I |=> MIN_TUNE_VOLTAGE_SEL_O == 2'h0 && AFC_GAIN_SEL_O == 2'h0 && !AFC_POLARITY_O)
    else $error("fields not cleared by reset");
  chk_reset_factor: assert property (disable iff (1'b0)
    SYS_RST_I |=> CHARGE_FACTOR_O == 4'h1 && MEASURE_WINDOW_N_O)
    else $error("factor or window wrong in reset");
  chk_gm_follow: assert property ($past(AFC_GAIN_SEL_O) != 2'h0 |->
    AFC_GM_FACTOR_O == CHARGE_FACTOR_O) else $error("gain factor differs");
  chk_gm_lowest: assert property ($past(AFC_GAIN_SEL_O) == 2'h0 |->
    AFC_GM_FACTOR_O == 4'h1) else $error("lowest gain was scaled");
  chk_factor_onehot: assert property ($onehot(CHARGE_FACTOR_O))
    else $error("charge factor illegal");
  chk_pd_noack: assert property (PWR_DOWN_I [*6] |-> !SDA_OE_O)
    else $error("ack during power-down");
  chk_window_len: assert property ($fell(MEASURE_WINDOW_N_O) && seen_q |->
    hi_q == PROC_CLKS) else $error("processing phase length wrong");
  chk_lock_hold: assert property (LOCK_FLAG_O || AFC_ACTIVE_O |->
    !TUNE_UP_O && !TUNE_DOWN_O) else $error("tuning while locked");
  chk_od_low: assert property (SDA_O == 1'b0 && OC_PORT_O == 4'h0)
    else $error("open drain drives high");
  cov_lock: cover property ($rose(LOCK_FLAG_O));
  cov_afc_only: cover property (AFC_ACTIVE_O && !LOCK_FLAG_O);
  cov_pd: cover property (PWR_DOWN_I [*6]);
endmodule // tvtc_chk

bind tvtc_ctrl tvtc_chk #(.PROC_CLKS(PROC_CLKS)) i_tvtc_chk (.*);
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
// Controller bench: bus master model, port and oscillator stimulus
module tb;
  logic       clk = 1'b0;  // System clock
  logic       rst = 1'b1;  // Sync reset
  logic       pd = 1'b0;   // Power-down request
  logic [1:0] ma = 2'h0;   // Module address strap
  logic       osc = 1'b0;  // Prescaled oscillator, ten edges per window
  logic [1:0] band = 2'h0; // Tuning voltage band
  logic [3:0] ext = 4'hf;  // Outside levels on the ports
  logic       scl, dn, sda_oe, sda_o, lk, afc, mw, up, dw, pol, s;
  logic [3:0] oc_oe, oc_o, bo, cf, gf;
  logic [1:0] tc, mv, gs;
  logic [2:0] ss;
  logic [7:0] r, b0, b1;
  int         bad_count = 0;
  int         comparisons = 0;
  int         e;
  wire        sda = !(dn || sda_oe); // Pulled up unless pulled low
  wire [3:0]  pin = ext & ~oc_oe;    // Open-collector port wires
  always #20 clk = ~clk;
  // Oscillator free of the system clock phase
  initial begin
    #7;
    forever #160 osc = ~osc;
  end
  tvtc_master i_tvtc_master (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_dn_o(dn));
  tvtc_ctrl #(.PROC_CLKS(20), .CYC256_CLKS(100), .CYC64_CLKS(40)) i_tvtc_ctrl (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .PWR_DOWN_I(pd), .MODULE_ADDR_I(ma), .PRESCALED_OSC_I(osc),
    .VTUN_BAND_I(band), .OC_PORT_I(pin), .OC_PORT_O(oc_o), .OC_PORT_OE_O(oc_oe),
    .BAND_OUT_O(bo), .LOCK_FLAG_O(lk), .AFC_ACTIVE_O(afc), .MEASURE_WINDOW_N_O(mw),
    .TUNE_UP_O(up), .TUNE_DOWN_O(dw), .TUNING_CURRENT_SEL_O(tc),
    .SENSITIVITY_SEL_O(ss), .MIN_TUNE_VOLTAGE_SEL_O(mv), .AFC_GAIN_SEL_O(gs),
    .AFC_POLARITY_O(pol), .CHARGE_FACTOR_O(cf), .AFC_GM_FACTOR_O(gf));
  // Compare and count
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Start and address byte, acknowledge expected or not
  task automatic ad(input logic [7:0] a, input logic x);
    i_tvtc_master.st();
    i_tvtc_master.xb(a, 1'b1, r, s);
    chk("ack", !s, x);
  endtask
  task automatic wr(input logic [7:0] ins, input logic [7:0] d);
    ad(8'hc0, 1'b1);
    i_tvtc_master.xb(ins, 1'b1, r, s);
    i_tvtc_master.xb(d, 1'b1, r, s);
    i_tvtc_master.sp();
    cy(4);
  endtask
  // Both information bytes, last one not acknowledged
  task automatic rd;
    ad(8'hc1, 1'b1);
    i_tvtc_master.xb(8'hff, 1'b0, b0, s);
    i_tvtc_master.xb(8'hff, 1'b1, b1, s);
    i_tvtc_master.sp();
  endtask
  // New frequency word, started in the counting phase
  task automatic fq(input logic [14:0] w);
    for (int i = 0; i < 300 && mw !== 1'b0; i++) cy(1);
    chk("mw", mw, 1'b0);
    if (mw !== 1'b0) finish_test();
    wr({1'b1, w[14:8]}, w[7:0]);
    cy(500);
  endtask
  // Main sequence
  initial begin
    cy(16);
    rst <= 1'b0;
    cy(1250);
    chk("rst", {oc_oe, bo}, 8'h00);
    chk("ctl", {pol, mv, gs, ss}, 8'h00);
    rd;
    chk("rstn", b0[3], 1'b0);
    chk("pinfo", b1, 8'hff);
    rd;
    chk("rstn", b0[3], 1'b1);
    wr(8'h29, 8'h51);
    chk("minv", mv, 2'h1);
    fq(15'd10);
    chk("lock", {lk, afc, up, dw}, 8'hc);
    rd;
    chk("gain", b0[7:5], 3'b101);
    rd;
    chk("gain", b0[7:5], 3'b111);
    fq(15'd14);
    chk("hold", {lk, afc}, 2'b01);
    fq(15'd20);
    rd;
    chk("lost", {b0[7:4], afc, up, dw}, 8'h22);
    fq(15'd5);
    rd;
    chk("fov", {b0[4], up, dw}, 3'b101);
    wr(8'h2b, 8'h0f);
    cy(300);
    chk("force", {afc, up, dw, pol}, 8'h9);
    wr(8'h2b, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h2a, 8'(8 + 32 * c));
      for (int b = 0; b < 4; b++) begin
        band <= 2'(b);
        cy(8);
        e = (b + c > 3) ? b + c - 3 : 0;
        chk("charge", cf, 8'(1 << e));
        chk("gm", gf, 8'(1 << e));
      end
    end
    chk("gsel", gs, 2'h1);
    wr(8'h2a, 8'h60);
    cy(8);
    chk("gm0", gf, 8'h1);
    chk("charge", cf, 8'h8);
    wr(8'h2c, 8'hc5);
    chk("port", {oc_oe, bo}, 8'h35);
    rd;
    ext <= 4'h3;
    cy(8);
    ext <= 4'h7;
    cy(8);
    rd;
    chk("pinfo", b1, 8'h84);
    rd;
    chk("pinfo", b1, 8'hf4);
    ad(8'hc1, 1'b1);
    i_tvtc_master.xb(8'hff, 1'b1, r, s);
    i_tvtc_master.xb(8'hff, 1'b1, r, s);
    i_tvtc_master.sp();
    chk("nack", r, 8'hff);
    ma <= 2'h1;
    for (int m = 0; m < 4; m++) begin
      ad(8'(192 + 2 * m), m < 2);
      i_tvtc_master.sp();
    end
    pd <= 1'b1;
    cy(8);
    ad(8'hc0, 1'b0);
    i_tvtc_master.sp();
    chk("pd", {oc_oe, bo}, 8'h00);
    pd <= 1'b0;
    cy(1250);
    rd;
    chk("rstn", b0[3], 1'b0);
    wr(8'h2c, 8'h05);
    wr(8'h29, 8'h40);
    for (int k = 5; k < 7; k++) begin
      ad(8'h00, 1'b1);
      i_tvtc_master.xb(8'(k), 1'b1, r, s);
      chk("gack", s, 1'b0);
      i_tvtc_master.sp();
      cy(1250);
      chk("gc", {mv, bo}, (k == 5) ? 8'h15 : 8'h00);
    end
    finish_test();
  end
endmodule // tb
`default_nettype wire
